// *** hw/svrp_pkg.sv ***
package svrp_pkg;

   // Register offsets (low address byte of the port's APB window).
   localparam logic [7:0] CTRL_OFS = 8'he0;
   localparam logic [7:0] TOP_OFS = 8'he4;
   localparam logic [7:0] SIDE_OFS = 8'he8;
   localparam logic [7:0] HOLD_OFS = 8'hec;
   localparam logic [7:0] STAT_OFS = 8'hf0;

   // Register reset values.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0400;
   localparam logic [11:0] TOP_RESET = 12'h000;
   localparam logic [31:0] SIDE_RESET = 32'h0000_0000;

   // Timing counts in video clock edges and bits per word.
   localparam logic [2:0] SYNC_LAST_EDGE = 3'h4;
   localparam logic [4:0] WORD_LAST_BIT = 5'h1f;

   // Status register field positions.
   localparam int STAT_DRQ_POS = 0;
   localparam int STAT_SHIFT_POS = 1;
   localparam int STAT_HOLD_POS = 2;
   localparam int STAT_PAGE_POS = 3;
   localparam int STAT_STATE_POS = 4;

   typedef enum logic [1:0]
   {
      MODE_OFF = 2'h0,
      MODE_IRQ = 2'h1,
      MODE_DMA0 = 2'h2,
      MODE_DMA1 = 2'h3
   } svrp_mode_e;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_WAIT = 3'h1,
      ST_DELAY = 3'h3,
      ST_LEFT = 3'h2,
      ST_DATA = 3'h6
   } svrp_state_e;

   typedef struct packed
   {
      logic [16:0] rsv_hi;
      logic [3:0] clock_divide;
      logic data_direction;
      svrp_mode_e mode;
      logic clock_edge_select;
      logic rsv6;
      logic page_sync_direction;
      logic page_sync_polarity;
      logic page_sync_level;
      logic line_sync_polarity;
      logic shift_direction;
      logic output_level_invert;
   } svrp_ctrl_s;

   typedef struct packed
   {
      logic [3:0] rsv_hi;
      logic [11:0] left_margin_clocks;
      logic [15:0] bits_per_line;
   } svrp_side_s;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } svrp_apb_req_s;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } svrp_apb_rsp_s;

   typedef struct packed
   {
      logic serial_video_out;
      logic serial_video_oe;
      logic page_sync_out;
      logic page_sync_oe;
   } svrp_pins_s;

   typedef struct packed
   {
      logic irq;
      logic dma0;
      logic dma1;
   } svrp_req_s;

endpackage : svrp_pkg

// *** hw/svrp_port.sv ***
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module svrp_port
(
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESET_N,
   // APB register bus.
   input wire svrp_pkg::svrp_apb_req_s APB_REQ,
   output svrp_pkg::svrp_apb_rsp_s APB_RSP,
   // Raster engine pins.
   input wire logic VIDEO_CLOCK_PIN,
   input wire logic LINE_SYNC_PIN,
   input wire logic PAGE_SYNC_IN,
   input wire logic SERIAL_VIDEO_IN,
   output svrp_pkg::svrp_pins_s PINS,
   // Service requests.
   output svrp_pkg::svrp_req_s REQ
);

   typedef struct packed
   {
      svrp_pkg::svrp_ctrl_s ctrl;
      logic [11:0] top_margin_lines;
      svrp_pkg::svrp_side_s side;
      logic [31:0] holding_word;
      logic [31:0] shift_reg;
      logic [11:0] top_cnt;
      logic [11:0] left_cnt;
      logic [15:0] line_cnt;
      logic [4:0] bit_cnt;
      logic [3:0] div_cnt;
      logic div_phase;
      logic [2:0] delay_cnt;
      svrp_pkg::svrp_state_e st;
      logic shift_full;
      logic holding_full;
      logic data_request_flag;
      logic [2:0] video_clock_pin_sync;
      logic [1:0] line_sync;
      logic [1:0] page_sync;
      logic [1:0] video_sync;
      logic line_prev;
      logic page_prev;
      svrp_pkg::svrp_apb_rsp_s apb;
      svrp_pkg::svrp_pins_s pins;
      svrp_pkg::svrp_req_s req;
   } svrp_regs_s;

   svrp_regs_s r;
   svrp_regs_s next_r;

   // Maps an address to a register number; 7 marks an unmapped address.
   function automatic logic [2:0] svrp_decode(input logic [7:0] addr);
      case (addr)
         svrp_pkg::CTRL_OFS: svrp_decode = 3'h0;
         svrp_pkg::TOP_OFS: svrp_decode = 3'h1;
         svrp_pkg::SIDE_OFS: svrp_decode = 3'h2;
         svrp_pkg::HOLD_OFS: svrp_decode = 3'h3;
         svrp_pkg::STAT_OFS: svrp_decode = 3'h4;
         default: svrp_decode = 3'h7;
      endcase
   endfunction : svrp_decode

   always_comb
   begin
      logic vedge;
      logic tick;
      logic enabled;
      logic tx;
      logic line_act;
      logic page_act;
      logic access;
      logic wr;
      logic rd;
      logic sample;
      logic in_bit;
      logic cur_bit;
      logic [2:0] sel;
      logic [31:0] rdata;
      logic [31:0] shifted;
      svrp_pkg::svrp_ctrl_s wctrl;
      svrp_pkg::svrp_ctrl_s rctrl;
      vedge = 1'b0;
      tick = 1'b0;
      enabled = 1'b0;
      tx = 1'b0;
      line_act = 1'b0;
      page_act = 1'b0;
      access = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      sample = 1'b0;
      in_bit = 1'b0;
      cur_bit = 1'b0;
      sel = 3'h7;
      rdata = 32'h0000_0000;
      shifted = 32'h0000_0000;
      wctrl = svrp_pkg::svrp_ctrl_s'(APB_REQ.pwdata);
      rctrl = r.ctrl;
      next_r = r;

      // Pin synchronisers.
      next_r.video_clock_pin_sync = {r.video_clock_pin_sync[1:0], VIDEO_CLOCK_PIN};
      next_r.line_sync = {r.line_sync[0], LINE_SYNC_PIN};
      next_r.page_sync = {r.page_sync[0], PAGE_SYNC_IN};
      next_r.video_sync = {r.video_sync[0], SERIAL_VIDEO_IN};

      enabled = r.ctrl.mode != svrp_pkg::MODE_OFF;
      tx = !r.ctrl.data_direction;
      if (r.ctrl.clock_edge_select)
         vedge = !r.video_clock_pin_sync[1] && r.video_clock_pin_sync[2];
      else
         vedge = r.video_clock_pin_sync[1] && !r.video_clock_pin_sync[2];

      // Syncs are sampled on the active video clock edge.
      if (vedge)
      begin
         next_r.line_prev = r.line_sync[1];
         next_r.page_prev = r.page_sync[1];
      end
      if (r.ctrl.line_sync_polarity)
         line_act = vedge && r.line_prev && !r.line_sync[1];
      else
         line_act = vedge && !r.line_prev && r.line_sync[1];
      if (r.ctrl.page_sync_polarity)
         page_act = vedge && r.page_prev && !r.page_sync[1];
      else
         page_act = vedge && !r.page_prev && r.page_sync[1];
      page_act = page_act && !r.ctrl.page_sync_direction;

      // Interface clock divider.
      if (r.ctrl.clock_divide == 4'h0)
         tick = vedge;
      else
      begin
         tick = vedge && r.div_phase
            && (r.div_cnt == r.ctrl.clock_divide - 4'h1);
         if (vedge)
         begin
            if (r.div_cnt == r.ctrl.clock_divide - 4'h1)
            begin
               next_r.div_cnt = 4'h0;
               next_r.div_phase = !r.div_phase;
            end
            else
               next_r.div_cnt = r.div_cnt + 4'h1;
         end
      end

      // APB slave: one wait cycle, then the answer.
      access = APB_REQ.psel && APB_REQ.penable;
      next_r.apb.pready = access && !r.apb.pready;
      wr = access && r.apb.pready && APB_REQ.pwrite;
      rd = access && r.apb.pready && !APB_REQ.pwrite;
      sel = svrp_decode(APB_REQ.paddr);
      rctrl.page_sync_level = r.ctrl.page_sync_direction
         ? r.ctrl.page_sync_level
         : r.page_sync[1] ^ r.ctrl.page_sync_polarity;
      case (sel)
         3'h0: rdata = 32'(rctrl);
         3'h1: rdata = {20'h00000, r.top_margin_lines};
         3'h2: rdata = 32'(r.side);
         3'h3: rdata = r.holding_word;
         3'h4:
         begin
            rdata[svrp_pkg::STAT_DRQ_POS] = r.data_request_flag;
            rdata[svrp_pkg::STAT_SHIFT_POS] = r.shift_full;
            rdata[svrp_pkg::STAT_HOLD_POS] = r.holding_full;
            rdata[svrp_pkg::STAT_PAGE_POS] = rctrl.page_sync_level;
            rdata[svrp_pkg::STAT_STATE_POS +: 3] = r.st;
         end
         default: rdata = 32'h0000_0000;
      endcase
      if (access && !r.apb.pready)
      begin
         next_r.apb.prdata = APB_REQ.pwrite ? 32'h0000_0000 : rdata;
         next_r.apb.pslverr = sel == 3'h7;
      end
      else
      begin
         next_r.apb.prdata = 32'h0000_0000;
         next_r.apb.pslverr = 1'b0;
      end

      if (wr)
      begin
         case (sel)
            3'h0:
            begin
               next_r.ctrl = wctrl;
               next_r.ctrl.rsv_hi = 17'h00000;
               next_r.ctrl.rsv6 = 1'b0;
               if (enabled && tx && r.ctrl.page_sync_direction
                  && wctrl.page_sync_direction
                  && !r.ctrl.page_sync_level && wctrl.page_sync_level)
                  page_act = 1'b1;
            end
            3'h1: next_r.top_margin_lines = APB_REQ.pwdata[11:0];
            3'h2:
            begin
               next_r.side = svrp_pkg::svrp_side_s'(APB_REQ.pwdata);
               next_r.side.rsv_hi = 4'h0;
            end
            3'h3:
            begin
               next_r.holding_word = APB_REQ.pwdata;
               if (tx)
               begin
                  next_r.holding_full = 1'b1;
                  next_r.data_request_flag = 1'b0;
               end
            end
            default: next_r.ctrl = r.ctrl;
         endcase
      end
      if (rd && sel == 3'h3 && !tx)
         next_r.data_request_flag = 1'b0;

      if (!enabled)
      begin
         // Disabled: machines idle, programmed registers kept.
         next_r.st = svrp_pkg::ST_IDLE;
         next_r.shift_reg = 32'h0000_0000;
         next_r.shift_full = 1'b0;
         next_r.holding_full = 1'b0;
         next_r.data_request_flag = 1'b0;
         next_r.top_cnt = 12'h000;
         next_r.left_cnt = 12'h000;
         next_r.line_cnt = 16'h0000;
         next_r.bit_cnt = 5'h00;
         next_r.delay_cnt = 3'h0;
         next_r.div_cnt = 4'h0;
         next_r.div_phase = 1'b0;
      end
      else if (tx)
      begin
         if (!r.shift_full && r.holding_full)
         begin
            next_r.shift_reg = r.holding_word;
            next_r.shift_full = 1'b1;
            next_r.holding_full = 1'b0;
            next_r.bit_cnt = 5'h00;
            next_r.data_request_flag = 1'b1;
         end
         cur_bit = r.ctrl.shift_direction ? r.shift_reg[31] : r.shift_reg[0];
         case (r.st)
            svrp_pkg::ST_IDLE:
            begin
               if (page_act)
               begin
                  next_r.top_cnt = r.top_margin_lines;
                  next_r.left_cnt = r.side.left_margin_clocks;
                  next_r.line_cnt = r.side.bits_per_line;
                  next_r.st = svrp_pkg::ST_WAIT;
               end
            end
            svrp_pkg::ST_WAIT:
            begin
               if (line_act)
               begin
                  if (!r.shift_full)
                     next_r.st = svrp_pkg::ST_IDLE;
                  else if (r.top_cnt != 12'h000)
                     next_r.top_cnt = r.top_cnt - 12'h001;
                  else
                  begin
                     next_r.st = svrp_pkg::ST_DELAY;
                     next_r.delay_cnt = 3'h0;
                  end
               end
            end
            svrp_pkg::ST_DELAY:
            begin
               if (vedge)
               begin
                  next_r.delay_cnt = r.delay_cnt + 3'h1;
                  if (r.delay_cnt == svrp_pkg::SYNC_LAST_EDGE)
                  begin
                     next_r.div_cnt = 4'h0;
                     next_r.div_phase = 1'b0;
                     if (r.left_cnt == 12'h000)
                        next_r.st = svrp_pkg::ST_DATA;
                     else
                        next_r.st = svrp_pkg::ST_LEFT;
                  end
               end
            end
            svrp_pkg::ST_LEFT:
            begin
               if (tick)
               begin
                  next_r.left_cnt = r.left_cnt - 12'h001;
                  if (r.left_cnt == 12'h001)
                  begin
                     next_r.left_cnt = r.side.left_margin_clocks;
                     next_r.st = svrp_pkg::ST_DATA;
                  end
               end
            end
            svrp_pkg::ST_DATA:
            begin
               if (tick)
               begin
                  next_r.line_cnt = r.line_cnt - 16'h0001;
                  if (r.line_cnt <= 16'h0001)
                  begin
                     next_r.shift_reg = 32'h0000_0000;
                     next_r.shift_full = 1'b0;
                     next_r.bit_cnt = 5'h00;
                     next_r.line_cnt = r.side.bits_per_line;
                     next_r.st = svrp_pkg::ST_WAIT;
                  end
                  else if (r.shift_full)
                  begin
                     if (r.bit_cnt == svrp_pkg::WORD_LAST_BIT)
                     begin
                        next_r.bit_cnt = 5'h00;
                        next_r.shift_reg = r.holding_word;
                        next_r.shift_full = r.holding_full;
                        if (r.holding_full)
                        begin
                           next_r.holding_full = 1'b0;
                           next_r.data_request_flag = 1'b1;
                        end
                     end
                     else
                     begin
                        next_r.bit_cnt = r.bit_cnt + 5'h01;
                        if (r.ctrl.shift_direction)
                           next_r.shift_reg = {r.shift_reg[30:0], 1'b0};
                        else
                           next_r.shift_reg = {1'b0, r.shift_reg[31:1]};
                     end
                  end
               end
            end
            default: next_r.st = svrp_pkg::ST_IDLE;
         endcase
         if (line_act && !r.shift_full && r.st != svrp_pkg::ST_IDLE)
            next_r.st = svrp_pkg::ST_IDLE;
      end
      else
      begin
         // Receive: page sync and margins play no part.
         in_bit = r.video_sync[1];
         case (r.st)
            svrp_pkg::ST_WAIT:
            begin
               if (line_act)
               begin
                  next_r.line_cnt = r.side.bits_per_line;
                  next_r.delay_cnt = 3'h0;
                  next_r.st = svrp_pkg::ST_DELAY;
               end
            end
            svrp_pkg::ST_DELAY:
            begin
               if (vedge)
               begin
                  next_r.delay_cnt = r.delay_cnt + 3'h1;
                  if (r.delay_cnt == svrp_pkg::SYNC_LAST_EDGE)
                  begin
                     sample = 1'b1;
                     next_r.div_cnt = 4'h0;
                     next_r.div_phase = 1'b0;
                     next_r.st = svrp_pkg::ST_DATA;
                  end
               end
            end
            svrp_pkg::ST_DATA: sample = tick;
            default: next_r.st = svrp_pkg::ST_WAIT;
         endcase
         if (sample)
         begin
            if (r.line_cnt == 16'h0000)
               next_r.st = svrp_pkg::ST_WAIT;
            else
            begin
               if (r.ctrl.shift_direction)
                  shifted = {r.shift_reg[30:0], in_bit};
               else
                  shifted = {in_bit, r.shift_reg[31:1]};
               next_r.shift_reg = shifted;
               next_r.shift_full = 1'b1;
               next_r.bit_cnt = r.bit_cnt + 5'h01;
               next_r.line_cnt = r.line_cnt - 16'h0001;
               if (r.bit_cnt == svrp_pkg::WORD_LAST_BIT
                  || r.line_cnt == 16'h0001)
               begin
                  next_r.holding_word = shifted;
                  next_r.data_request_flag = 1'b1;
                  next_r.shift_reg = 32'h0000_0000;
                  next_r.shift_full = 1'b0;
                  next_r.bit_cnt = 5'h00;
               end
               if (r.line_cnt == 16'h0001)
                  next_r.st = svrp_pkg::ST_WAIT;
            end
         end
      end

      // Turning the port on.
      if (wr && sel == 3'h0 && !enabled
         && wctrl.mode != svrp_pkg::MODE_OFF)
      begin
         if (!wctrl.data_direction)
            next_r.data_request_flag = 1'b1;
         else
            next_r.st = svrp_pkg::ST_WAIT;
      end

      // Registered pins and request lines.
      cur_bit = next_r.ctrl.shift_direction
         ? next_r.shift_reg[31] : next_r.shift_reg[0];
      next_r.pins.serial_video_out = next_r.ctrl.output_level_invert
         ^ (cur_bit && next_r.shift_full && enabled
         && next_r.st == svrp_pkg::ST_DATA);
      next_r.pins.serial_video_oe = !next_r.ctrl.data_direction;
      next_r.pins.page_sync_out = next_r.ctrl.page_sync_level
         ^ next_r.ctrl.page_sync_polarity;
      next_r.pins.page_sync_oe = next_r.ctrl.page_sync_direction;
      next_r.req.irq = next_r.data_request_flag
         && next_r.ctrl.mode == svrp_pkg::MODE_IRQ;
      next_r.req.dma0 = next_r.data_request_flag
         && next_r.ctrl.mode == svrp_pkg::MODE_DMA0;
      next_r.req.dma1 = next_r.data_request_flag
         && next_r.ctrl.mode == svrp_pkg::MODE_DMA1;
   end

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         r <= '0;
         r.ctrl <= svrp_pkg::svrp_ctrl_s'(svrp_pkg::CTRL_RESET);
         r.top_margin_lines <= svrp_pkg::TOP_RESET;
         r.side <= svrp_pkg::svrp_side_s'(svrp_pkg::SIDE_RESET);
         r.st <= svrp_pkg::ST_IDLE;
      end
      else
         r <= next_r;
   end

   assign APB_RSP = r.apb;
   assign PINS = r.pins;
   assign REQ = r.req;

endmodule : svrp_port

`default_nettype wire

// *** tb/svrp_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module svrp_monitor
(
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESET_N,
   // Bus and pins.
   input wire svrp_pkg::svrp_apb_req_s APB_REQ,
   input wire svrp_pkg::svrp_apb_rsp_s APB_RSP,
   input wire logic VIDEO_CLOCK_PIN,
   input wire logic LINE_SYNC_PIN,
   input wire logic PAGE_SYNC_IN,
   input wire logic SERIAL_VIDEO_IN,
   input wire svrp_pkg::svrp_pins_s PINS,
   input wire svrp_pkg::svrp_req_s REQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   logic take;
   logic ctrl_wr;
   logic vprev;
   logic [3:0] quiet;
   logic was_off;
   assign take = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready;
   assign ctrl_wr = take & APB_REQ.pwrite
      & (APB_REQ.paddr == svrp_pkg::CTRL_OFS);
   // Counts clocks since the video clock pin last moved.
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         vprev <= 1'b0;
         quiet <= 4'hf;
         was_off <= 1'b1;
      end
      else
      begin
         vprev <= VIDEO_CLOCK_PIN;
         // Remembers whether the last control write left the port off.
         if (ctrl_wr)
            was_off <= APB_REQ.pwdata[9:8] == 2'h0;
         if (VIDEO_CLOCK_PIN != vprev)
            quiet <= 4'h0;
         else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
      end
   end
   sequence s_access;
      APB_REQ.psel && $rose(APB_REQ.penable);
   endsequence
   sequence s_ctrl_recent;
      $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
   endsequence
   a_bus_wait: assert property (s_access |->
      !APB_RSP.pready ##1 APB_RSP.pready)
      else $error("pready not after one wait cycle");
   a_pready_cause: assert property (APB_RSP.pready |->
      $past(APB_REQ.psel & APB_REQ.penable))
      else $error("pready without access phase");
   a_refuse_data: assert property (APB_RSP.pslverr |->
      APB_RSP.pready && APB_RSP.prdata == 32'h0)
      else $error("refused access returned data");
   a_req_onehot: assert property ($onehot0(REQ))
      else $error("more than one service request");
   a_req_off: assert property (ctrl_wr && APB_REQ.pwdata[9:8] == 2'h0
      |-> ##[1:6] REQ == 3'h0)
      else $error("request kept while disabled");
   a_tx_enable: assert property (ctrl_wr && was_off
      && !APB_REQ.pwdata[10] && APB_REQ.pwdata[9:8] != 2'h0
      |-> ##[1:6] REQ != 3'h0)
      else $error("transmit enable gave no request");
   a_oe_follows: assert property ($changed(PINS.serial_video_oe)
      |-> s_ctrl_recent)
      else $error("data pin enable moved without control write");
   a_page_sync_pin_oe: assert property ($changed(PINS.page_sync_oe)
      |-> s_ctrl_recent)
      else $error("page sync enable moved without control write");
   a_vid_quiet: assert property ($changed(PINS.serial_video_out)
      && PINS.serial_video_oe && !ctrl_wr && !$past(ctrl_wr)
      && !$past(ctrl_wr, 2) |-> quiet < 4'h9)
      else $error("data pin moved away from a video clock edge");
endmodule : svrp_monitor

bind svrp_port svrp_monitor i_mon
(
   .MCLK(MCLK),
   .RESET_N(RESET_N),
   .APB_REQ(APB_REQ),
   .APB_RSP(APB_RSP),
   .VIDEO_CLOCK_PIN(VIDEO_CLOCK_PIN),
   .LINE_SYNC_PIN(LINE_SYNC_PIN),
   .PAGE_SYNC_IN(PAGE_SYNC_IN),
   .SERIAL_VIDEO_IN(SERIAL_VIDEO_IN),
   .PINS(PINS),
   .REQ(REQ)
);

`default_nettype wire

// *** tb/svrp_engine.sv ***
`timescale 1ns/1ns
`default_nettype none

module svrp_engine
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Bench controls.
   input wire logic run,
   input wire logic line_go,
   input wire logic page_level,
   input wire logic [31:0] rx_word,
   // Port pins.
   input wire logic data_out,
   output logic video_clock_pin,
   output logic line_sync_pin,
   output logic page_sync_pin,
   output logic data_in,
   output logic [63:0] seen
);
   logic [2:0] div;
   logic pend;
   int edges;
   // All lines change on the falling video edge, clear of the active one.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div <= 3'h0;
         pend <= 1'b0;
         edges <= 100;
         video_clock_pin <= 1'b0;
         line_sync_pin <= 1'b0;
         page_sync_pin <= 1'b0;
         data_in <= 1'b0;
         seen <= 64'h0;
      end
      else
      begin
         pend <= pend | line_go;
         if (run)
            div <= div + 3'h1;
         if (run && div == 3'h7)
         begin
            video_clock_pin <= ~video_clock_pin;
            if (!video_clock_pin)
               edges <= edges + 1;
            else
            begin
               seen <= {data_out, seen[63:1]};
               line_sync_pin <= pend;
               page_sync_pin <= page_level;
               pend <= line_go;
               if (pend)
                  edges <= -1;
               if (edges >= 4 && edges < 36)
                  data_in <= rx_word[5'(edges - 4)];
               else
                  data_in <= ~data_in;
            end
         end
      end
   end
endmodule : svrp_engine

`default_nettype wire

// *** tb/svrp_port_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module svrp_port_bench;
   logic MCLK;
   logic RESET_N;
   svrp_pkg::svrp_apb_req_s req;
   svrp_pkg::svrp_apb_rsp_s rsp;
   svrp_pkg::svrp_pins_s pins;
   svrp_pkg::svrp_req_s sreq;
   logic video_clock_pin, line_sync_pin, page_sync_pin, din, ps_pin, vd_pin;
   logic run, line_go, page_level, err, found;
   logic [63:0] seen;
   logic [31:0] q;
   int bad_count, checks;
   localparam logic [31:0] WA = 32'hc3a5_0f61;
   localparam logic [31:0] WB = 32'h0000_000d;
   assign ps_pin = pins.page_sync_oe ? pins.page_sync_out : page_sync_pin;
   assign vd_pin = pins.serial_video_oe ? pins.serial_video_out : din;
   svrp_port i_dut (.MCLK(MCLK), .RESET_N(RESET_N), .APB_REQ(req),
      .APB_RSP(rsp), .VIDEO_CLOCK_PIN(video_clock_pin), .LINE_SYNC_PIN(line_sync_pin),
      .PAGE_SYNC_IN(ps_pin), .SERIAL_VIDEO_IN(vd_pin), .PINS(pins),
      .REQ(sreq));
   svrp_engine i_eng (.clk(MCLK), .rst_n(RESET_N), .run(run),
      .line_go(line_go), .page_level(page_level), .rx_word(32'h0000_00c5),
      .data_out(vd_pin), .video_clock_pin(video_clock_pin), .line_sync_pin(line_sync_pin), .page_sync_pin(page_sync_pin),
      .data_in(din), .seen(seen));
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      logic rdy;
      rdy = 1'b0;
      @(posedge MCLK);
      req.psel <= 1'b1;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge MCLK);
      req.penable <= 1'b1;
      while (!rdy)
      begin
         @(posedge MCLK);
         rdy = (rsp.pready === 1'b1);
         q = rsp.prdata;
         err = rsp.pslverr;
      end
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer
   task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic line(input int n);
      @(posedge MCLK);
      line_go <= 1'b1;
      @(posedge MCLK);
      line_go <= 1'b0;
      repeat (n) @(negedge video_clock_pin);
   endtask : line
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial
   begin
      #300000;
      bad_count++;
      end_of_test();
   end
   initial
   begin
      RESET_N = 1'b0;
      req = '0;
      run = 1'b0;
      line_go = 1'b0;
      page_level = 1'b0;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge MCLK);
      RESET_N <= 1'b1;
      run <= 1'b1;
      xfer(1'b0, svrp_pkg::CTRL_OFS, 32'h0);
      check("ctrl", svrp_pkg::CTRL_RESET, q);
      xfer(1'b0, 8'h00, 32'h0);
      check("slverr", 32'h1, {31'h0, err});
      $display("test registers done");
      xfer(1'b1, svrp_pkg::CTRL_OFS, 32'h0000_0001);
      repeat (4) @(negedge MCLK);
      check("idle high", 32'h1, {31'h0, pins.serial_video_out});
      check("oe", 32'h1, {31'h0, pins.serial_video_oe});
      xfer(1'b1, svrp_pkg::CTRL_OFS, 32'h0);
      repeat (4) @(negedge MCLK);
      check("idle low", 32'h0, {31'h0, pins.serial_video_out});
      xfer(1'b1, svrp_pkg::TOP_OFS, 32'h1);
      xfer(1'b1, svrp_pkg::SIDE_OFS, 32'h0002_0024);
      for (int m = 3; m > 0; m--)
      begin
         xfer(1'b1, svrp_pkg::CTRL_OFS, 32'(m) << 8);
         repeat (6) @(negedge MCLK);
         check("req", 32'h4 >> (m - 1), {29'h0, sreq});
      end
      xfer(1'b1, svrp_pkg::HOLD_OFS, WA);
      repeat (40) @(negedge MCLK);
      xfer(1'b0, svrp_pkg::STAT_OFS, 32'h0);
      check("stat one", 32'h3, q & 32'h7);
      xfer(1'b1, svrp_pkg::HOLD_OFS, WB);
      repeat (40) @(negedge MCLK);
      xfer(1'b0, svrp_pkg::STAT_OFS, 32'h0);
      check("stat two", 32'h6, q & 32'h7);
      page_level <= 1'b1;
      repeat (16) @(negedge video_clock_pin);
      line(50);
      check("top line", 32'h0, seen[63:32] | seen[31:0]);
      line(50);
      found = 1'b0;
      for (int o = 0; o < 28; o++)
         if ((seen >> o) === {28'h0, WB[3:0], WA})
            found = 1'b1;
      check("line", 32'h1, {31'h0, found});
      check("refill", 32'h4, {29'h0, sreq});
      line(10);
      xfer(1'b0, svrp_pkg::STAT_OFS, 32'h0);
      check("page end", 32'h0, q & 32'h70);
      $display("test transmit done");
      xfer(1'b1, svrp_pkg::CTRL_OFS, 32'h0);
      xfer(1'b1, svrp_pkg::SIDE_OFS, 32'h0000_0008);
      xfer(1'b1, svrp_pkg::CTRL_OFS, 32'h0000_0602);
      line(20);
      check("rx req", 32'h2, {29'h0, sreq});
      xfer(1'b0, svrp_pkg::HOLD_OFS, 32'h0);
      check("rx data", 32'ha3, q & 32'hff);
      repeat (4) @(negedge MCLK);
      check("rx clear", 32'h0, {29'h0, sreq});
      $display("test receive done");
      xfer(1'b1, svrp_pkg::CTRL_OFS, 32'h0000_0030);
      repeat (4) @(negedge MCLK);
      q = {30'h0, pins.page_sync_oe, pins.page_sync_out};
      check("page_sync_pin", 32'h3, q);
      $display("test page sync done");
      end_of_test();
   end
endmodule : svrp_port_bench

`default_nettype wire
